// File: afes_pkg.sv
// Purpose: Shared constants for the converter front-end sequencer
// Assumes: 250 MHz system clock used as the converter master clock
// Notes: Register offsets are byte addresses on a 32-bit Avalon-MM port
package afes_pkg;
  // Register byte offsets
  localparam logic [3:0] AFES_OFF_CFG = 4'h0;
  localparam logic [3:0] AFES_OFF_CHAN = 4'h4;
  localparam logic [3:0] AFES_OFF_CTRL = 4'h8;
  localparam logic [3:0] AFES_OFF_STAT = 4'hC;
  // Configuration field positions
  localparam int AFES_CFG_LOOP_BIT = 0;
  localparam int AFES_CFG_CHOP_BIT = 1;
  localparam int AFES_CFG_BIAS_EN_BIT = 2;
  localparam int AFES_CFG_BIAS_HI_BIT = 3;
  localparam int AFES_CFG_SCAN_BIT = 4;
  localparam int AFES_CFG_DLY_LSB = 8;
  // Control register bits (pulse acts on a written one; run holds the written level)
  localparam int AFES_CTRL_PULSE_BIT = 0;
  localparam int AFES_CTRL_RUN_BIT = 1;
  // Reset values
  localparam logic [31:0] AFES_CFG_RST = 32'h0000_0000;
  localparam logic [15:0] AFES_CHAN_RST = 16'h0001;
  // One delay unit in master clock periods
  localparam int AFES_DLY_UNIT = 128;
  // Delay units per select code 000..111
  localparam logic [5:0] AFES_DLY_UNITS [8] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h10, 6'h20, 6'h30};
  // Default conversion length in master clock periods
  localparam int AFES_CONV_CYCLES = 64;
  // Sequencer states
  typedef enum logic [4:0] {
    AFES_IDLE = 5'b00001,
    AFES_SETTLE = 5'b00010,
    AFES_CONV = 5'b00100,
    AFES_DONE = 5'b01000,
    AFES_NEXT = 5'b10000
  } afes_state_t;
endpackage

// File: afes_delay_timer.sv
// Purpose: Switch-time delay counter for the front-end sequencer
// Assumes: Load and count on one clock, no enable divider needed
// Notes: Code 000 finishes in the cycle after the load
`timescale 1ns/1ns
module afes_delay_timer
  import afes_pkg::*;
#(
  parameter int CNT_W = 13
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic load,
  input wire logic [2:0] switch_delay_select,
  output logic expired
);
  logic [CNT_W-1:0] count_ff;
  logic busy_ff;
  logic [CNT_W-1:0] nxt_count;

  // Units times 128 master clocks, a shift since the unit is a power of two
  assign nxt_count = CNT_W'({7'h00, AFES_DLY_UNITS[switch_delay_select]} << $clog2(AFES_DLY_UNIT));

  // Count down to zero after each load
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_ff <= '0;
      busy_ff <= 1'b0;
    end else if (load) begin
      count_ff <= nxt_count;
      busy_ff <= 1'b1;
    end else if (count_ff != '0) begin
      count_ff <= count_ff - CNT_W'(1);
    end else begin
      busy_ff <= 1'b0;
    end
  end

  assign expired = busy_ff && (count_ff == '0);
endmodule

// File: afes_sequencer.sv
// Purpose: Channel scan, switch delay, external chop and sensor bias control
// Assumes: Converter result arrives as a signed word with a valid strobe
// Notes: Registers sit on an Avalon-MM slave that answers in one wait cycle
//
// Local design decisions: the address map and the Avalon-MM slave port.
`timescale 1ns/1ns
// Notes on behaviour
// - Loop bit 0 clear selects internal bypass path
// - Mux output pins always driven
// - Scan waits switch delay before converting
// - Delay adds to each channel's period
// - Pulse mode converts one channel per pulse
// - Chop in pulse mode still uses delay
// - Bias sources positive, sinks negative, two sizes; sink is on only in the second chop phase, source only outside it
// - Bias only on selected channel pair
// - Chop bit 1 enables external chopping
// - Chop takes two readings, polarity reversed
// - Chop result is average of both
// - Chop halves the result rate
// - Delay also inserted between chop phases
// - Delay codes 0..48 units of 128 clocks
// - Ready low on each new channel result
module afes_sequencer
  import afes_pkg::*;
#(
  parameter int CHANNELS = 16,
  parameter int DATA_W = 24
) (
  input wire logic clock,
  input wire logic reset_n,
  // Avalon-MM slave
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Conversion start pin, level sensitive in scan mode, rising edge in pulse mode, synchronous
  input wire logic start_pin,
  // Modulator side
  output logic conv_start,
  input wire logic conv_valid,
  input wire logic [DATA_W-1:0] conv_data,
  output logic polarity_swap,
  // Analog switch controls
  output logic [CHANNELS-1:0] mux_select,
  output logic mux_out_positive,
  output logic mux_out_negative,
  output logic loop_internal,
  output logic [CHANNELS-1:0] bias_source_en,
  output logic [CHANNELS-1:0] bias_sink_en,
  output logic bias_high,
  // Result
  output logic [DATA_W-1:0] result_data,
  output logic [$clog2(CHANNELS)-1:0] result_channel,
  output logic result_ready_n
);
  localparam int CH_W = $clog2(CHANNELS);

  logic [31:0] first_config_register_ff;
  logic [CHANNELS-1:0] chan_enable_ff;
  logic run_ff;
  logic pulse_pend_ff;
  logic start_pin_d_ff;
  logic ack_ff;
  afes_state_t state_ff;
  afes_state_t nxt_state;
  logic [CH_W-1:0] chan_ff;
  logic [CH_W-1:0] nxt_chan;
  logic phase_ff;
  logic [DATA_W:0] first_read_ff;
  logic [DATA_W-1:0] result_data_ff;
  logic [CH_W-1:0] result_channel_ff;
  logic ready_n_ff;
  logic load_delay;
  logic delay_expired;
  logic [31:0] rd_mux;
  logic cfg_sel;
  logic chan_sel;
  logic ctrl_sel;
  logic scan_mode;
  logic chop_en;
  logic trigger;
  logic acc;
  logic [DATA_W:0] sum;

  assign scan_mode = first_config_register_ff[AFES_CFG_SCAN_BIT];
  assign chop_en = first_config_register_ff[AFES_CFG_CHOP_BIT];
  assign acc = (avs_read || avs_write) && !ack_ff;
  assign cfg_sel = avs_address == AFES_OFF_CFG;
  assign chan_sel = avs_address == AFES_OFF_CHAN;
  assign ctrl_sel = avs_address == AFES_OFF_CTRL;

  // One wait state per access keeps read data registered
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ack_ff <= 1'b0;
    end else begin
      ack_ff <= acc;
    end
  end
  assign avs_waitrequest = (avs_read || avs_write) && !ack_ff;

  // Configuration registers written on the accepting edge
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      first_config_register_ff <= AFES_CFG_RST;
      chan_enable_ff <= CHANNELS'(AFES_CHAN_RST);
    end else if (avs_write && ack_ff) begin
      if (cfg_sel) begin
        first_config_register_ff <= avs_writedata & 32'h0000_071F;
      end
      if (chan_sel) begin
        chan_enable_ff <= avs_writedata[CHANNELS-1:0];
      end
    end
  end

  // Run level from software or pin; pulse requests are sticky until used
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      run_ff <= 1'b0;
      pulse_pend_ff <= 1'b0;
      start_pin_d_ff <= 1'b0;
    end else begin
      start_pin_d_ff <= start_pin;
      if (avs_write && ack_ff && ctrl_sel) begin
        run_ff <= avs_writedata[AFES_CTRL_RUN_BIT];
      end
      // A new pulse beats consumption in the same cycle
      if ((avs_write && ack_ff && ctrl_sel && avs_writedata[AFES_CTRL_PULSE_BIT]) ||
          (start_pin && !start_pin_d_ff)) begin
        pulse_pend_ff <= 1'b1;
      end else if (state_ff == AFES_IDLE || scan_mode) begin // Scan drops stale pulses
        pulse_pend_ff <= 1'b0;
      end
    end
  end

  assign trigger = scan_mode ? (run_ff || start_pin) : pulse_pend_ff;

  // Register read mux, unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      AFES_OFF_CFG: rd_mux = first_config_register_ff;
      AFES_OFF_CHAN: rd_mux = 32'(chan_enable_ff);
      AFES_OFF_CTRL: rd_mux = {30'h0, run_ff, pulse_pend_ff};
      AFES_OFF_STAT: rd_mux = {16'h0, 3'h0, state_ff, 3'h0, ready_n_ff, 4'(chan_ff)};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_ff) begin
      avs_readdata <= rd_mux;
    end
  end

  // Next enabled channel after the current one, wraps around
  always_comb begin
    nxt_chan = chan_ff;
    for (int i = CHANNELS; i >= 1; i--) begin
      if (chan_enable_ff[CH_W'((32'(chan_ff) + i) % CHANNELS)]) begin
        nxt_chan = CH_W'((32'(chan_ff) + i) % CHANNELS);
      end
    end
  end

  // Sequencer: every channel switch and chop reversal reloads the delay
  always_comb begin
    nxt_state = state_ff;
    load_delay = 1'b0;
    unique case (state_ff)
      AFES_IDLE: begin
        if (trigger) begin
          nxt_state = AFES_SETTLE;
          load_delay = 1'b1;
        end
      end
      AFES_SETTLE: begin
        if (delay_expired) begin
          nxt_state = AFES_CONV;
        end
      end
      AFES_CONV: begin
        if (conv_valid) begin
          if (chop_en && !phase_ff) begin
            nxt_state = AFES_SETTLE;
            load_delay = 1'b1;
          end else begin
            nxt_state = AFES_DONE;
          end
        end
      end
      AFES_DONE: begin
        nxt_state = AFES_NEXT;
      end
      AFES_NEXT: begin
        // Pulse mode stops after one channel
        if (scan_mode && (run_ff || start_pin)) begin
          nxt_state = AFES_SETTLE;
          load_delay = 1'b1;
        end else begin
          nxt_state = AFES_IDLE;
        end
      end
      default: nxt_state = AFES_IDLE;
    endcase
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      state_ff <= AFES_IDLE;
      chan_ff <= '0;
      phase_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      // Mux moves in the same edge the delay loads
      if (state_ff == AFES_NEXT && nxt_state == AFES_SETTLE) begin
        chan_ff <= nxt_chan;
      end else if (state_ff == AFES_IDLE && nxt_state == AFES_SETTLE && !chan_enable_ff[chan_ff]) begin
        chan_ff <= nxt_chan;
      end
      if (state_ff == AFES_CONV && conv_valid) begin
        phase_ff <= chop_en && !phase_ff;
      end else if (state_ff == AFES_IDLE) begin
        phase_ff <= 1'b0;
      end
    end
  end

  afes_delay_timer u_delay (
    .clock(clock),
    .reset_n(reset_n),
    .load(load_delay),
    .switch_delay_select(first_config_register_ff[AFES_CFG_DLY_LSB +: 3]),
    .expired(delay_expired)
  );

  // Sign-extended sum of both phases; second phase is negated to undo the reversal
  assign sum = first_read_ff - {conv_data[DATA_W-1], conv_data};

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      first_read_ff <= '0;
      result_data_ff <= '0;
      result_channel_ff <= '0;
    end else if (state_ff == AFES_CONV && conv_valid) begin
      if (chop_en && !phase_ff) begin
        first_read_ff <= {conv_data[DATA_W-1], conv_data};
      end else if (chop_en) begin
        result_data_ff <= sum[DATA_W:1];
        result_channel_ff <= chan_ff;
      end else begin
        result_data_ff <= conv_data;
        result_channel_ff <= chan_ff;
      end
    end
  end

  // Ready drops for each result; a one-cycle high gap marks the next one
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      ready_n_ff <= 1'b1;
    end else if (state_ff == AFES_DONE) begin
      ready_n_ff <= 1'b0;
    end else if (state_ff == AFES_CONV && conv_valid && !(chop_en && !phase_ff)) begin
      ready_n_ff <= 1'b1;
    end else if (avs_read && ack_ff && avs_address == AFES_OFF_STAT) begin
      ready_n_ff <= 1'b1;
    end
  end

  assign conv_start = (state_ff == AFES_SETTLE) && delay_expired;
  assign polarity_swap = phase_ff;
  assign loop_internal = !first_config_register_ff[AFES_CFG_LOOP_BIT];
  assign mux_out_positive = 1'b1;
  assign mux_out_negative = 1'b1;
  assign bias_high = first_config_register_ff[AFES_CFG_BIAS_HI_BIT];
  assign result_data = result_data_ff;
  assign result_channel = result_channel_ff;
  assign result_ready_n = ready_n_ff;

  // Per-channel mux and bias gating; bias follows only the selected pair
  for (genvar g = 0; g < CHANNELS; g++) begin : g_ch
    assign mux_select[g] = (32'(chan_ff) == g);
    assign bias_source_en[g] = first_config_register_ff[AFES_CFG_BIAS_EN_BIT] &&
                               (32'(chan_ff) == g) && !phase_ff;
    assign bias_sink_en[g] = first_config_register_ff[AFES_CFG_BIAS_EN_BIT] &&
                             (32'(chan_ff) == g) && phase_ff;
  end
endmodule

// File: afes_modulator_model.sv
// Purpose: Modulator stand-in that answers each conversion start
// Assumes: Latency comes from lat, polarity is taken at the start strobe
// Notes: Data toggles outside the strobe so a stale word never matches
`timescale 1ns/1ns
module afes_modulator_model (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic conv_start,
  input wire logic polarity_swap,
  input wire logic [7:0] lat,
  input wire logic [23:0] level,
  input wire logic [23:0] offset,
  output logic conv_valid,
  output logic [23:0] conv_data
);
  int cnt;
  logic swap_ff;
  // Count down from the start strobe, then give one reading
  always @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      cnt = 0;
      swap_ff <= 1'b0;
      conv_valid <= 1'b0;
      conv_data <= 24'h000000;
    end else begin
      conv_valid <= 1'b0;
      conv_data <= ~conv_data;
      if (conv_start) begin
        cnt = lat + 1;
        swap_ff <= polarity_swap;
      end else if (cnt == 1) begin
        cnt = 0;
        conv_valid <= 1'b1;
        conv_data <= (swap_ff ? -level : level) + offset;
      end else if (cnt > 1) begin
        cnt = cnt - 1;
      end
    end
  end
endmodule

// File: afes_sequencer_props.sv
// Purpose: Port-level assertions for the front-end sequencer
// Assumes: A register write lands at the edge where waitrequest is low
// Notes: Sees only top ports; bound below the module
`timescale 1ns/1ns
module afes_sequencer_props
  import afes_pkg::*;
#(
  parameter int CHANNELS = 16
) (
  input wire logic clock,
  input wire logic reset_n,
  input wire logic [3:0] avs_address,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic avs_waitrequest,
  input wire logic conv_start,
  input wire logic conv_valid,
  input wire logic polarity_swap,
  input wire logic [CHANNELS-1:0] mux_select,
  input wire logic mux_out_positive,
  input wire logic mux_out_negative,
  input wire logic loop_internal,
  input wire logic [CHANNELS-1:0] bias_source_en,
  input wire logic [CHANNELS-1:0] bias_sink_en,
  input wire logic bias_high,
  input wire logic result_ready_n
);
  default clocking @(posedge clock); endclocking
  default disable iff (!reset_n);
  logic cfg_wr;
  // Config write taken at this edge
  assign cfg_wr = avs_write && !avs_waitrequest && avs_address == AFES_OFF_CFG;
  loop_path_a: assert property (cfg_wr |=> loop_internal == !$past(avs_writedata[AFES_CFG_LOOP_BIT]))
    else $error("loop path does not follow config write");
  pins_driven_a: assert property (mux_out_positive && mux_out_negative)
    else $error("mux output pins not driven");
  bias_size_a: assert property (cfg_wr |=> bias_high == $past(avs_writedata[AFES_CFG_BIAS_HI_BIT]))
    else $error("bias size does not follow config write");
  bias_select_a: assert property (((bias_source_en | bias_sink_en) & ~mux_select) == '0)
    else $error("bias on an unselected channel");
  mux_onehot_a: assert property ($onehot(mux_select))
    else $error("mux selection not one channel");
  start_pulse_a: assert property (conv_start |=> !conv_start)
    else $error("conversion start longer than one cycle");
  chop_channel_a: assert property ($rose(polarity_swap) |-> $stable(mux_select))
    else $error("channel changed between chop phases");
  ready_cause_a: assert property ($fell(result_ready_n) |-> $past(conv_valid) || $past(conv_valid, 2)
    || $past(conv_valid, 3))
    else $error("ready without a fresh reading");
endmodule
bind afes_sequencer afes_sequencer_props #(.CHANNELS(CHANNELS)) u_props (.clock(clock), .reset_n(reset_n),
  .avs_address(avs_address), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_waitrequest(avs_waitrequest), .conv_start(conv_start), .conv_valid(conv_valid),
  .polarity_swap(polarity_swap), .mux_select(mux_select), .mux_out_positive(mux_out_positive),
  .mux_out_negative(mux_out_negative), .loop_internal(loop_internal), .bias_source_en(bias_source_en),
  .bias_sink_en(bias_sink_en), .bias_high(bias_high), .result_ready_n(result_ready_n));

// File: afes_sequencer_tb.sv
// Purpose: Self-checking bench for the front-end sequencer
// Assumes: Bus waits for waitrequest low at a rising edge; outputs logged at negedge
// Notes: Delay checks use differences, so fixed pipeline cost cancels
`timescale 1ns/1ns
module afes_sequencer_tb;
  import afes_pkg::*;
  logic clock = 1'b0, reset_n = 1'b0, avs_read = 1'b0, avs_write = 1'b0, start_pin = 1'b0, rdy_q = 1'b1;
  logic [3:0] avs_address = 4'h0, result_channel, rq[$];
  logic [31:0] avs_writedata = 32'h0, avs_readdata, seed = 32'h0000DDFF;
  logic avs_waitrequest, conv_start, conv_valid, polarity_swap, mux_out_positive, mux_out_negative;
  logic loop_internal, bias_high, result_ready_n;
  logic [23:0] conv_data, result_data, level = 24'h0, offset = 24'h0, dq[$];
  logic [15:0] mux_select, bias_source_en, bias_sink_en;
  logic [7:0] lat = 8'h04;
  int errors = 0, check_count = 0, cyc = 0, sq[$], vq[$];
  afes_sequencer u_afes_sequencer (.clock(clock), .reset_n(reset_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .start_pin(start_pin), .conv_start(conv_start),
    .conv_valid(conv_valid), .conv_data(conv_data), .polarity_swap(polarity_swap),
    .mux_select(mux_select), .mux_out_positive(mux_out_positive), .mux_out_negative(mux_out_negative),
    .loop_internal(loop_internal), .bias_source_en(bias_source_en), .bias_sink_en(bias_sink_en),
    .bias_high(bias_high), .result_data(result_data), .result_channel(result_channel),
    .result_ready_n(result_ready_n));
  afes_modulator_model u_afes_modulator_model (.clock(clock), .reset_n(reset_n), .conv_start(conv_start),
    .polarity_swap(polarity_swap), .lat(lat), .level(level), .offset(offset), .conv_valid(conv_valid),
    .conv_data(conv_data));
  always #2 clock = ~clock;
  // Cycle count; the ceiling cuts a hang short
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      errors++;
      finish_test();
    end
  end
  // Log starts, readings and each new result at mid-cycle
  always @(negedge clock) begin
    if (conv_start === 1'b1) sq.push_back(cyc);
    if (conv_valid === 1'b1) vq.push_back(cyc);
    if (result_ready_n === 1'b0 && rdy_q === 1'b1) begin
      rq.push_back(result_channel);
      dq.push_back(result_data);
    end
    rdy_q = result_ready_n;
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // One bus cycle; held until waitrequest is sampled low at a rising edge, data taken there
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge clock);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic cfg(input logic [31:0] d);
    logic [31:0] q;
    seed = xs(seed);
    level <= {{4{seed[19]}}, seed[19:0]};
    offset <= {{12{seed[31]}}, seed[31:20]};
    lat <= {4'h0, seed[23:20]} + 8'h01;
    bus(1'b1, AFES_OFF_CFG, d, q);
    check("loop", loop_internal, !d[0]);
    check("bias size", bias_high, d[3]);
  endtask
  // No local limit: a hang is ended by the cycle ceiling and counted there
  task automatic wait_res(input int n);
    while (rq.size() < n) @(posedge clock);
  endtask
  task automatic finish_test();
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    logic [31:0] q;
    int t0, d0, n0, v0;
    repeat (16) @(posedge clock);
    reset_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, AFES_OFF_CFG, 32'h0, q);
    check("cfg reset", q, AFES_CFG_RST);
    bus(1'b0, AFES_OFF_CHAN, 32'h0, q);
    check("chan reset", q, {16'h0000, AFES_CHAN_RST});
    $display("reset values done");
    // Every delay code, one pulse each; delay measured against code 000
    for (int k = 0; k < 8; k++) begin
      cfg(32'(k) << AFES_CFG_DLY_LSB);
      n0 = sq.size();
      t0 = cyc;
      bus(1'b1, AFES_OFF_CTRL, 32'h1, q);
      wait_res(k + 1);
      if (k == 0) d0 = sq[n0] - t0;
      check("delay", sq[n0] - t0 - d0, AFES_DLY_UNITS[k] * AFES_DLY_UNIT);
      check("data", dq[k], 24'(level + offset));
      repeat (200) @(posedge clock);
      check("starts per pulse", sq.size() - n0, 1);
    end
    $display("delay sweep done");
    // Start pin pulse also converts one channel
    n0 = sq.size();
    start_pin <= 1'b1;
    @(posedge clock);
    start_pin <= 1'b0;
    wait_res(9);
    repeat (200) @(posedge clock);
    check("pin pulse starts", sq.size() - n0, 1);
    $display("pin pulse done");
    // Chop in pulse mode with delay code 011
    cfg(32'h0000_0303);
    n0 = sq.size();
    v0 = vq.size();
    bus(1'b1, AFES_OFF_CTRL, 32'h1, q);
    wait_res(10);
    repeat (200) @(posedge clock);
    check("chop average", dq[9], level);
    check("chop starts", sq.size() - n0, 2);
    check("chop gap", sq[n0 + 1] - vq[v0] >= 512, 1);
    $display("chop done");
    // Scan channels 0 and 2 with the larger bias; chop left off as monitor reads need
    cfg(32'h0000_011C);
    bus(1'b1, AFES_OFF_CHAN, 32'h5, q);
    start_pin <= 1'b1;
    wait_res(13);
    start_pin <= 1'b0;
    check("bias on selected", bias_source_en | bias_sink_en, 32'(mux_select));
    for (int i = 0; i < 3; i++) begin
      check("scan channel", rq[10 + i], i[0] ? 4'h2 : 4'h0);
      check("scan data", dq[10 + i], 24'(level + offset));
    end
    repeat (1500) @(posedge clock);
    bus(1'b0, 4'h2, 32'h0, q);
    check("unmapped", q, 32'h0);
    $display("scan done");
    // Same channels again with the smaller bias, run by the control bit this time
    cfg(32'h0000_0114);
    n0 = rq.size();
    bus(1'b1, AFES_OFF_CTRL, 32'h2, q);
    wait_res(n0 + 2);
    bus(1'b1, AFES_OFF_CTRL, 32'h0, q);
    check("rescan pair", rq[n0] ^ rq[n0 + 1], 4'h2);
    check("rescan data", dq[n0], 24'(level + offset));
    check("rescan data", dq[n0 + 1], 24'(level + offset));
    repeat (400) @(posedge clock);
    // Status shows idle with a result pending; reading it raises ready again
    bus(1'b0, AFES_OFF_STAT, 32'h0, q);
    check("status", q, {16'h0, 3'h0, AFES_IDLE, 3'h0, 1'b0, rq[rq.size() - 1]});
    check("ready after read", result_ready_n, 1'b1);
    cfg(32'h0000_0000); // Bias off again, readings taken with it served only as a
    $display("rescan done");
    finish_test();
  end
endmodule
